/* hw/ctr_timer_pkg.sv */
// Purpose: shared constants and types of the dual event counter/timer
// Assumes: 32-bit avalon-mm data, byte addresses, one word per register
// Notes:   source codes index the per-cycle source vector directly
package ctr_timer_pkg;

  localparam int unsigned DATA_W       = 32;
  localparam int unsigned ADDR_W       = 6;
  localparam int unsigned NUM_CHANNELS = 2;
  localparam int unsigned SRC_W        = 5;
  localparam int unsigned MODE_W       = 3;
  localparam int unsigned NUM_SOURCES  = 19;
  localparam int unsigned NUM_LINES    = 4;
  localparam int unsigned NUM_USER     = 4;
  localparam int unsigned NUM_LOGIC    = 2;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CHANNEL_SELECT = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_COUNT_SOURCE   = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_START_SOURCE   = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_CLEAR_SOURCE   = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_START_DELAY    = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_RUN_LENGTH     = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_LIVE_COUNT     = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_CAPTURED       = 6'h1c;
  localparam logic [ADDR_W-1:0] OFF_CHANNEL_STATE  = 6'h20;

  // field positions inside the three source registers
  localparam int unsigned SRC_LSB  = 0;
  localparam int unsigned MODE_LSB = 8;

  // source codes
  localparam logic [SRC_W-1:0] SRC_OFF            = 5'h00;
  localparam logic [SRC_W-1:0] SRC_MHZ_TICK       = 5'h01;
  localparam logic [SRC_W-1:0] SRC_LINE0          = 5'h02;
  localparam logic [SRC_W-1:0] SRC_USER0          = 5'h06;
  localparam logic [SRC_W-1:0] SRC_CH0_DELAY_DONE = 5'h0a;
  localparam logic [SRC_W-1:0] SRC_CH1_DELAY_DONE = 5'h0b;
  localparam logic [SRC_W-1:0] SRC_CH0_RUN_DONE   = 5'h0c;
  localparam logic [SRC_W-1:0] SRC_CH1_RUN_DONE   = 5'h0d;
  localparam logic [SRC_W-1:0] SRC_LOGIC0         = 5'h0e;
  localparam logic [SRC_W-1:0] SRC_EXPOSURE_START = 5'h10;
  localparam logic [SRC_W-1:0] SRC_EXPOSURE_END   = 5'h11;
  localparam logic [SRC_W-1:0] SRC_FRAME_ARM_WAIT = 5'h12;

  // qualify modes
  localparam logic [MODE_W-1:0] QUAL_LEVEL_LOW  = 3'h0;
  localparam logic [MODE_W-1:0] QUAL_LEVEL_HIGH = 3'h1;
  localparam logic [MODE_W-1:0] QUAL_FALLING    = 3'h2;
  localparam logic [MODE_W-1:0] QUAL_RISING     = 3'h3;
  localparam logic [MODE_W-1:0] QUAL_ANY_EDGE   = 3'h4;

  // values after reset
  localparam logic [SRC_W-1:0]  RST_SOURCE = SRC_OFF;
  localparam logic [MODE_W-1:0] RST_MODE   = QUAL_RISING;

  // megahertz tick
  localparam int unsigned       CLK_PERIOD_NS  = 4;
  localparam int unsigned       TICK_PERIOD_NS = 1000;
  localparam int unsigned       TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned       TICK_CNT_W     = 8;
  localparam logic [TICK_CNT_W-1:0] TICK_LAST  = 8'(TICK_CYCLES - 1);

  typedef enum logic [2:0] {
    CH_IDLE,
    CH_TRIGGER_WAIT,
    CH_ACTIVE,
    CH_COMPLETED,
    CH_OVERFLOW
  } chan_state_t;

endpackage

/* hw/line_sync.sv */
// Purpose: three-stage synchroniser for asynchronous line pins
// Assumes: pins are unrelated to the system clock
// Notes:   a change is taken once stages two and three agree
`timescale 1ns/100ps
module line_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // s1 feeds only s2, so metastability cannot reach any decision
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.q;

endmodule

/* hw/dual_event_counter_timer.sv */
// Purpose: two event counter/timer channels behind an avalon-mm slave
// Assumes: line pins are asynchronous; all other sources share CLK_SYS_IN
// Notes:   tags below mark the logic that carries each rule
// Operation
// [RULE1] two independent channels 0 and 1; a selector picks the accessed one
// [RULE2] count source: tick, line, user output, channel events, logic, exposure
// [RULE3] count qualify: level low, level high, falling, rising or any edge
// [RULE4] delay-done event fires when count reaches the programmed delay
// [RULE5] run-done event fires when count reaches the programmed run length
// [RULE6] start and clear sources exclusive; choosing one turns the other off
// [RULE7] start source, from the same set, begins counting when it fires
// [RULE8] start qualify: level low, level high, falling, rising or any edge
// [RULE9] clear source, from the same set, ends and zeroes the count; the code zeroes it but the channel goes active and counts on
// [RULE10] clear qualify: level low, level high, falling, rising or any edge
// [RULE11] live count of each channel is readable at any time
// [RULE12] a clear captures the count into a separate readable value
// [RULE13] a read-only state register shows each channel's operating state
// [RULE14] state is idle, trigger wait, active, completed or overflow
// [RULE15] at run length the channel stops and reports completed until restarted
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module dual_event_counter_timer
  import ctr_timer_pkg::*;
#(
  parameter int unsigned CNT_W = 32
) (
  input  wire logic                               CLK_SYS_IN,
  input  wire logic                               RST_N_IN,
  input  wire logic [ctr_timer_pkg::ADDR_W-1:0]   AVS_ADDRESS_IN,
  input  wire logic                               AVS_READ_IN,
  input  wire logic                               AVS_WRITE_IN,
  input  wire logic [ctr_timer_pkg::DATA_W-1:0]   AVS_WRITEDATA_IN,
  input  wire logic [ctr_timer_pkg::DATA_W/8-1:0] AVS_BYTEENABLE_IN,
  output logic      [ctr_timer_pkg::DATA_W-1:0]   AVS_READDATA_OUT,
  output logic                                    AVS_WAITREQUEST_OUT,
  input  wire logic [ctr_timer_pkg::NUM_LINES-1:0] LINE_IN,
  input  wire logic [ctr_timer_pkg::NUM_USER-1:0] USER_OUTPUT_IN,
  input  wire logic [ctr_timer_pkg::NUM_LOGIC-1:0] LOGIC_BLOCK_IN,
  input  wire logic                               EXPOSURE_START_IN,
  input  wire logic                               EXPOSURE_END_IN,
  input  wire logic                               FRAME_ARM_WAIT_IN,
  output logic [ctr_timer_pkg::NUM_CHANNELS-1:0]  DELAY_DONE_EVENT_OUT,
  output logic [ctr_timer_pkg::NUM_CHANNELS-1:0]  RUN_DONE_EVENT_OUT
);

  import ctr_timer_pkg::*;

  if (CNT_W < 1 || CNT_W > DATA_W) begin : g_bad_width
    $error("CNT_W must lie between 1 and the bus data width");
  end

  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  typedef struct packed {
    logic                                 wait_r;
    logic [DATA_W-1:0]                    rdata;
    logic                                 sel;
    logic [NUM_CHANNELS-1:0][SRC_W-1:0]   cnt_src;
    logic [NUM_CHANNELS-1:0][MODE_W-1:0]  cnt_mode;
    logic [NUM_CHANNELS-1:0][SRC_W-1:0]   start_src;
    logic [NUM_CHANNELS-1:0][MODE_W-1:0]  start_mode;
    logic [NUM_CHANNELS-1:0][SRC_W-1:0]   clear_src;
    logic [NUM_CHANNELS-1:0][MODE_W-1:0]  clear_mode;
    logic [NUM_CHANNELS-1:0][CNT_W-1:0]   delay;
    logic [NUM_CHANNELS-1:0][CNT_W-1:0]   runlen;
    logic [NUM_CHANNELS-1:0][CNT_W-1:0]   count;
    logic [NUM_CHANNELS-1:0][CNT_W-1:0]   captured;
    chan_state_t [NUM_CHANNELS-1:0]       cstate;
    logic [NUM_CHANNELS-1:0]              delay_done;
    logic [NUM_CHANNELS-1:0]              run_done;
    logic [NUM_SOURCES-1:0]               prev_src;
    logic [TICK_CNT_W-1:0]                tick_cnt;
    logic                                 tick;
  } state_t;

  localparam state_t ST_RST = '{
    wait_r:     1'b1,
    cnt_src:    {NUM_CHANNELS{RST_SOURCE}},
    start_src:  {NUM_CHANNELS{RST_SOURCE}},
    clear_src:  {NUM_CHANNELS{RST_SOURCE}},
    cnt_mode:   {NUM_CHANNELS{RST_MODE}},
    start_mode: {NUM_CHANNELS{RST_MODE}},
    clear_mode: {NUM_CHANNELS{RST_MODE}},
    default:    '0
  };

  state_t                 st_r;
  state_t                 st_nxt;
  logic [NUM_LINES-1:0]   line_level;
  logic [NUM_SOURCES-1:0] src_vec;

  line_sync #(
    .WIDTH (NUM_LINES)
  ) u_line_sync (
    .clk_in    (CLK_SYS_IN),
    .rst_n_in  (RST_N_IN),
    .pin_in    (LINE_IN),
    .level_out (line_level)
  );

  // one-cycle sources ignore the qualify mode: they are already events
  function automatic logic is_pulse(input logic [SRC_W-1:0] code);
    return code == SRC_MHZ_TICK || code == SRC_CH0_DELAY_DONE ||
           code == SRC_CH1_DELAY_DONE || code == SRC_CH0_RUN_DONE ||
           code == SRC_CH1_RUN_DONE;
  endfunction

  // shared qualifier for the count, start and clear selections
  function automatic logic src_fire(input logic [SRC_W-1:0]       code,
                                    input logic [MODE_W-1:0]      mode,
                                    input logic [NUM_SOURCES-1:0] cur,
                                    input logic [NUM_SOURCES-1:0] prev);
    logic c;
    logic p;
    logic f;
    c = 1'b0;
    p = 1'b0;
    f = 1'b0;
    if (code != SRC_OFF && int'(code) < NUM_SOURCES) begin
      c = cur[code];
      p = prev[code];
      if (is_pulse(code)) begin
        f = c;
      end else begin
        unique case (mode)
          QUAL_LEVEL_LOW:  f = !c;
          QUAL_LEVEL_HIGH: f = c;
          QUAL_FALLING:    f = p && !c;
          QUAL_RISING:     f = !p && c;
          QUAL_ANY_EDGE:   f = p != c;
          default:         f = 1'b0;
        endcase
      end
    end
    return f;
  endfunction

  function automatic logic [DATA_W-1:0] be_merge(
      input logic [DATA_W-1:0]   old_v,
      input logic [DATA_W-1:0]   new_v,
      input logic [DATA_W/8-1:0] be);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < DATA_W / 8; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] pack_src(
      input logic [SRC_W-1:0]  src,
      input logic [MODE_W-1:0] mode);
    logic [DATA_W-1:0] r;
    r = '0;
    r[SRC_LSB +: SRC_W]   = src;
    r[MODE_LSB +: MODE_W] = mode;
    return r;
  endfunction

  // channel events are taken from their registers to avoid loops
  always_comb begin
    src_vec                                = '0;
    src_vec[SRC_MHZ_TICK]                  = st_r.tick;
    src_vec[SRC_LINE0 +: NUM_LINES]        = line_level;
    src_vec[SRC_USER0 +: NUM_USER]         = USER_OUTPUT_IN;
    src_vec[SRC_CH0_DELAY_DONE]            = st_r.delay_done[0];
    src_vec[SRC_CH1_DELAY_DONE]            = st_r.delay_done[1];
    src_vec[SRC_CH0_RUN_DONE]              = st_r.run_done[0];
    src_vec[SRC_CH1_RUN_DONE]              = st_r.run_done[1];
    src_vec[SRC_LOGIC0 +: NUM_LOGIC]       = LOGIC_BLOCK_IN;
    src_vec[SRC_EXPOSURE_START]            = EXPOSURE_START_IN;
    src_vec[SRC_EXPOSURE_END]              = EXPOSURE_END_IN;
    src_vec[SRC_FRAME_ARM_WAIT]            = FRAME_ARM_WAIT_IN;
  end

  always_comb begin
    logic              c;
    logic              acc;
    logic              cfg_wr;
    logic [DATA_W-1:0] rd;
    logic [DATA_W-1:0] wv;
    logic [DATA_W-1:0] old;
    logic              cnt_hit;
    logic              start_hit;
    logic              clear_hit;
    logic [CNT_W-1:0]  inc;
    c         = st_r.sel;
    acc       = !st_r.wait_r && AVS_WRITE_IN;
    cfg_wr    = 1'b0;
    rd        = '0;
    wv        = '0;
    old       = '0;
    cnt_hit   = 1'b0;
    start_hit = 1'b0;
    clear_hit = 1'b0;
    inc       = '0;
    st_nxt    = st_r;

    // megahertz tick
    if (st_r.tick_cnt == TICK_LAST) begin
      st_nxt.tick_cnt = '0;
      st_nxt.tick     = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
      st_nxt.tick     = 1'b0;
    end
    st_nxt.prev_src = src_vec;

    // read mux for the selected channel
    unique case (AVS_ADDRESS_IN)
      OFF_CHANNEL_SELECT: rd = DATA_W'(st_r.sel);
      OFF_COUNT_SOURCE:   rd = pack_src(st_r.cnt_src[c], st_r.cnt_mode[c]);
      OFF_START_SOURCE:   rd = pack_src(st_r.start_src[c], st_r.start_mode[c]);
      OFF_CLEAR_SOURCE:   rd = pack_src(st_r.clear_src[c], st_r.clear_mode[c]);
      OFF_START_DELAY:    rd = DATA_W'(st_r.delay[c]);
      OFF_RUN_LENGTH:     rd = DATA_W'(st_r.runlen[c]);
      OFF_LIVE_COUNT:     rd = DATA_W'(st_r.count[c]); // RULE11
      OFF_CAPTURED:       rd = DATA_W'(st_r.captured[c]); // RULE12
      OFF_CHANNEL_STATE:  rd = DATA_W'(st_r.cstate[c]); // RULE13
      default:            rd = '0;
    endcase

    // one wait cycle, then waitrequest low for exactly one cycle
    st_nxt.wait_r = 1'b1;
    st_nxt.rdata  = '0;
    if (st_r.wait_r && (AVS_READ_IN || AVS_WRITE_IN)) begin
      st_nxt.wait_r = 1'b0;
      st_nxt.rdata  = AVS_READ_IN ? rd : '0;
    end

    // writes land on the edge that completes the transfer
    if (acc) begin
      unique case (AVS_ADDRESS_IN)
        OFF_CHANNEL_SELECT: old = DATA_W'(st_r.sel);
        OFF_COUNT_SOURCE:   old = pack_src(st_r.cnt_src[c], st_r.cnt_mode[c]);
        OFF_START_SOURCE:   old = pack_src(st_r.start_src[c],
                                           st_r.start_mode[c]);
        OFF_CLEAR_SOURCE:   old = pack_src(st_r.clear_src[c],
                                           st_r.clear_mode[c]);
        OFF_START_DELAY:    old = DATA_W'(st_r.delay[c]);
        OFF_RUN_LENGTH:     old = DATA_W'(st_r.runlen[c]);
        OFF_CAPTURED:       old = DATA_W'(st_r.captured[c]);
        default:            old = '0;
      endcase
      wv = be_merge(old, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
      unique case (AVS_ADDRESS_IN)
        OFF_CHANNEL_SELECT: st_nxt.sel = wv[0]; // RULE1
        OFF_COUNT_SOURCE: begin
          st_nxt.cnt_src[c]  = wv[SRC_LSB +: SRC_W]; // RULE2
          st_nxt.cnt_mode[c] = wv[MODE_LSB +: MODE_W]; // RULE3
          cfg_wr             = 1'b1;
        end
        OFF_START_SOURCE: begin
          st_nxt.start_src[c]  = wv[SRC_LSB +: SRC_W]; // RULE7
          st_nxt.start_mode[c] = wv[MODE_LSB +: MODE_W]; // RULE8
          if (wv[SRC_LSB +: SRC_W] != SRC_OFF) begin
            st_nxt.clear_src[c] = SRC_OFF; // RULE6
          end
          cfg_wr = 1'b1;
        end
        OFF_CLEAR_SOURCE: begin
          st_nxt.clear_src[c]  = wv[SRC_LSB +: SRC_W]; // RULE9
          st_nxt.clear_mode[c] = wv[MODE_LSB +: MODE_W]; // RULE10
          if (wv[SRC_LSB +: SRC_W] != SRC_OFF) begin
            st_nxt.start_src[c] = SRC_OFF; // RULE6
          end
          cfg_wr = 1'b1;
        end
        OFF_START_DELAY: begin
          st_nxt.delay[c] = wv[CNT_W-1:0];
          cfg_wr          = 1'b1;
        end
        OFF_RUN_LENGTH: begin
          st_nxt.runlen[c] = wv[CNT_W-1:0];
          cfg_wr           = 1'b1;
        end
        OFF_CAPTURED: st_nxt.captured[c] = wv[CNT_W-1:0];
        default: ;
      endcase
    end

    // channels run on the old configuration this cycle
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      st_nxt.delay_done[i] = 1'b0;
      st_nxt.run_done[i]   = 1'b0;
      cnt_hit   = src_fire(st_r.cnt_src[i], st_r.cnt_mode[i],
                           src_vec, st_r.prev_src); // RULE2 RULE3
      start_hit = src_fire(st_r.start_src[i], st_r.start_mode[i],
                           src_vec, st_r.prev_src); // RULE7 RULE8
      clear_hit = src_fire(st_r.clear_src[i], st_r.clear_mode[i],
                           src_vec, st_r.prev_src); // RULE9 RULE10
      inc = st_r.count[i] + 1'b1;
      if (clear_hit) begin
        // capture beats a same-cycle software write of the captured value
        st_nxt.captured[i] = st_r.count[i]; // RULE12
        st_nxt.count[i]    = '0; // RULE9
        st_nxt.cstate[i]   = (st_r.cnt_src[i] == SRC_OFF) ? CH_IDLE
                                                         : CH_ACTIVE;
      end else begin
        unique case (st_r.cstate[i]) // RULE14
          CH_IDLE: begin
            if (st_r.cnt_src[i] != SRC_OFF) begin
              st_nxt.count[i]  = '0;
              st_nxt.cstate[i] = (st_r.start_src[i] != SRC_OFF) ?
                                 CH_TRIGGER_WAIT : CH_ACTIVE;
            end
          end
          CH_TRIGGER_WAIT, CH_COMPLETED, CH_OVERFLOW: begin
            if (start_hit) begin
              st_nxt.count[i]  = '0; // RULE7
              st_nxt.cstate[i] = CH_ACTIVE;
            end
          end
          CH_ACTIVE: begin
            if (cnt_hit) begin
              if (st_r.count[i] == CNT_MAX) begin
                // count holds at full scale rather than wrapping
                st_nxt.cstate[i] = CH_OVERFLOW; // RULE14
              end else begin
                st_nxt.count[i] = inc;
                if (st_r.delay[i] != '0 && inc == st_r.delay[i]) begin
                  st_nxt.delay_done[i] = 1'b1; // RULE4
                end
                if (st_r.runlen[i] != '0 && inc == st_r.runlen[i]) begin
                  st_nxt.run_done[i] = 1'b1; // RULE5
                  st_nxt.cstate[i]   = CH_COMPLETED; // RULE15
                end
              end
            end
          end
        endcase
      end
    end

    // reconfiguring a channel drops it back to idle to restart cleanly
    if (cfg_wr) begin
      st_nxt.count[c]  = '0;
      st_nxt.cstate[c] = CH_IDLE;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign AVS_READDATA_OUT     = st_r.rdata;
  assign AVS_WAITREQUEST_OUT  = st_r.wait_r;
  assign DELAY_DONE_EVENT_OUT = st_r.delay_done;
  assign RUN_DONE_EVENT_OUT   = st_r.run_done;

endmodule

/* test/io_partner.sv */
// Purpose: camera-side model of lines, user outputs, logic and exposure
// Assumes: bench moves pat_in and aux_in just after rising edges
// Notes:   one pattern feeds every source kind, so the first code of each kind sees it
`timescale 1ns/100ps
module io_partner (
  input  wire logic       pat_in,
  input  wire logic       aux_in,
  output logic      [3:0] line_out,
  output logic      [3:0] user_out,
  output logic      [1:0] logic_out,
  output logic      [2:0] exp_out
);
  // spare lines 1 and 3 toggle against the pattern, line 2 with it, so they never look idle
  assign line_out  = {~pat_in, pat_in, ~pat_in, pat_in};
  assign user_out  = {aux_in, aux_in, aux_in, pat_in};
  assign logic_out = {aux_in, pat_in};
  assign exp_out   = {pat_in, pat_in, pat_in};
endmodule

/* test/ctr_checker.sv */
// Purpose: port-level checks of the counter/timer block
// Assumes: avalon-mm answer one cycle after a taken request
// Notes:   configuration is not decoded here, so event checks stay generic
`timescale 1ns/100ps
module ctr_checker
  import ctr_timer_pkg::*;
(
  input wire logic                   CLK_SYS_IN,
  input wire logic                   RST_N_IN,
  input wire logic [ADDR_W-1:0]      AVS_ADDRESS_IN,
  input wire logic                   AVS_READ_IN,
  input wire logic                   AVS_WRITE_IN,
  input wire logic [DATA_W-1:0]      AVS_READDATA_OUT,
  input wire logic                   AVS_WAITREQUEST_OUT,
  input wire logic [NUM_CHANNELS-1:0] DELAY_DONE_EVENT_OUT,
  input wire logic [NUM_CHANNELS-1:0] RUN_DONE_EVENT_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  reset_quiet_a: assert property (!$past(RST_N_IN) |-> AVS_WAITREQUEST_OUT
    && DELAY_DONE_EVENT_OUT == 2'h0 && RUN_DONE_EVENT_OUT == 2'h0)
    else $error("outputs active right after reset");
  answer_next_a: assert property ((AVS_READ_IN || AVS_WRITE_IN)
    && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
    else $error("request not answered in the next cycle");
  answer_once_a: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("answer longer than one cycle");
  answer_cause_a: assert property (!AVS_WAITREQUEST_OUT |->
    $past(AVS_READ_IN || AVS_WRITE_IN))
    else $error("answer without request");
  rdata_idle_a: assert property (AVS_WAITREQUEST_OUT |-> AVS_READDATA_OUT == 32'h0)
    else $error("read data outside answer");
  wr_answer_zero_a: assert property (!AVS_WAITREQUEST_OUT && $past(AVS_WRITE_IN)
    |-> AVS_READDATA_OUT == 32'h0)
    else $error("read data on write answer");
  delay_single_a: assert property (|DELAY_DONE_EVENT_OUT |=>
    (DELAY_DONE_EVENT_OUT & $past(DELAY_DONE_EVENT_OUT)) == 2'h0)
    else $error("delay event wider than one cycle");
  run_single_a: assert property (|RUN_DONE_EVENT_OUT |=>
    (RUN_DONE_EVENT_OUT & $past(RUN_DONE_EVENT_OUT)) == 2'h0)
    else $error("run event wider than one cycle");
  cover property (|RUN_DONE_EVENT_OUT);
  cover property (|DELAY_DONE_EVENT_OUT);
  cover property (AVS_READ_IN && !AVS_WAITREQUEST_OUT);
endmodule
bind dual_event_counter_timer ctr_checker ctr_checker_inst (.CLK_SYS_IN,
  .RST_N_IN, .AVS_ADDRESS_IN, .AVS_READ_IN, .AVS_WRITE_IN, .AVS_READDATA_OUT,
  .AVS_WAITREQUEST_OUT, .DELAY_DONE_EVENT_OUT, .RUN_DONE_EVENT_OUT);

/* test/dual_event_counter_timer_tb.sv */
// Purpose: self-checking bench of the dual event counter/timer
// Assumes: partner model drives all external event sources from pat and aux
// Notes:   bus answers are taken at the rising edge that ends the cycle with waitrequest low
`timescale 1ns/100ps
module dual_event_counter_timer_tb;
  import ctr_timer_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic              rd = 1'b0;
  logic              wr = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [3:0]        be = 4'hf;
  logic [DATA_W-1:0] rdata, got;
  logic              waitreq, pat = 1'b0, aux = 1'b0, c, p, idle;
  logic [3:0]        line, user;
  logic [1:0]        lgc, dly_ev, run_ev;
  logic [2:0]        expo, m;
  int                errors = 0, n_checks = 0, ch, len, dl, f, k;
  int                n_dly [2], n_run [2];
  logic [SRC_W-1:0]  srcs [6] = '{SRC_USER0, SRC_LINE0, SRC_LOGIC0,
                        SRC_EXPOSURE_START, SRC_EXPOSURE_END, SRC_FRAME_ARM_WAIT};

  always #2 clk = ~clk;
  always @(negedge clk) begin
    for (int i = 0; i < 2; i++) begin
      n_dly[i] += int'(dly_ev[i] === 1'b1);
      n_run[i] += int'(run_ev[i] === 1'b1);
    end
  end

  dual_event_counter_timer dual_event_counter_timer_inst (
    .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(waitreq), .LINE_IN(line), .USER_OUTPUT_IN(user),
    .LOGIC_BLOCK_IN(lgc), .EXPOSURE_START_IN(expo[0]),
    .EXPOSURE_END_IN(expo[1]), .FRAME_ARM_WAIT_IN(expo[2]),
    .DELAY_DONE_EVENT_OUT(dly_ev), .RUN_DONE_EVENT_OUT(run_ev));
  io_partner io_partner_inst (.pat_in(pat), .aux_in(aux), .line_out(line),
    .user_out(user), .logic_out(lgc), .exp_out(expo));

  task automatic tally_and_finish();
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic is_rd, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [3:0] b);
    int n;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    rd <= is_rd;
    wr <= ~is_rd;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    if (n == 20) begin
      errors++;
      tally_and_finish();
    end
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus(1'b0, a, d, 4'hf);
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    bus(1'b1, a, 32'h0, 4'hf);
    chk(got, e);
  endtask
  task automatic pulse_pat(input int n);
    @(posedge clk);
    pat <= 1'b1;
    repeat (n) @(posedge clk);
    pat <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  function automatic logic [DATA_W-1:0] sv(logic [4:0] s, logic [2:0] q);
    return {21'h0, q, 3'h0, s};
  endfunction
  function automatic int fire(logic [2:0] q, logic cur, logic prv);
    return int'((q == QUAL_LEVEL_LOW && !cur) || (q == QUAL_LEVEL_HIGH && cur)
      || (q == QUAL_FALLING && prv && !cur) || (q == QUAL_RISING && !prv && cur)
      || (q == QUAL_ANY_EDGE && prv != cur));
  endfunction

  initial begin
    void'($urandom(56117));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) rchk(6'(4 * i), (i > 0 && i < 4) ? 32'h300 : 32'h0);
    wreg(OFF_LIVE_COUNT, $urandom);
    rchk(OFF_LIVE_COUNT, 32'h0);
    wreg(OFF_CHANNEL_STATE, 32'h3);
    rchk(OFF_CHANNEL_STATE, 32'h0);
    wreg(6'h24, 32'h5);
    rchk(6'h24, 32'h0);
    rchk(6'h02, 32'h0);
    bus(1'b0, OFF_CAPTURED, 32'hffffffff, 4'h2);
    rchk(OFF_CAPTURED, 32'h0000ff00);
    wreg(OFF_START_SOURCE, sv(5'(SRC_USER0 + 1), QUAL_RISING));
    wreg(OFF_CLEAR_SOURCE, sv(SRC_LOGIC0, QUAL_FALLING));
    bus(1'b1, OFF_START_SOURCE, 32'h0, 4'hf);
    chk(32'(got[4:0]), 32'h0);
    wreg(OFF_START_SOURCE, sv(5'(SRC_USER0 + 1), QUAL_RISING));
    bus(1'b1, OFF_CLEAR_SOURCE, 32'h0, 4'hf);
    chk(32'(got[4:0]), 32'h0);
    wreg(OFF_CHANNEL_SELECT, 32'h1);
    rchk(OFF_CLEAR_SOURCE, 32'h300);
    // every mode and every partner-driven source in srcs, both channels in turn
    for (int i = 0; i < 10; i++) begin
      ch = i % 2;
      m = 3'(i % 5);
      len = $urandom_range(9, 2);
      dl = $urandom_range(len - 1, 1);
      idle = (m == QUAL_LEVEL_LOW);
      pat <= idle;
      wreg(OFF_CHANNEL_SELECT, 32'(ch));
      wreg(OFF_START_SOURCE, sv(SRC_OFF, QUAL_RISING));
      wreg(OFF_START_DELAY, 32'(dl));
      wreg(OFF_RUN_LENGTH, 32'(len));
      wreg(OFF_COUNT_SOURCE, sv(srcs[i % 6], m));
      repeat (6) @(posedge clk);
      n_dly[ch] = 0;
      n_run[ch] = 0;
      f = 0;
      p = idle;
      for (int j = 0; j < 12; j++) begin
        c = 1'($urandom_range(1, 0));
        @(posedge clk);
        pat <= c;
        f += fire(m, c, p) + fire(m, c, c);
        p = c;
        // each value stands two cycles so the line filter passes it
        @(posedge clk);
      end
      @(posedge clk);
      pat <= idle;
      f += fire(m, idle, p);
      repeat (8) @(posedge clk);
      rchk(OFF_LIVE_COUNT, 32'((f < len) ? f : len));
      rchk(OFF_CHANNEL_STATE, (f >= len) ? 32'h3 : 32'h2);
      chk(32'(n_run[ch]), 32'(f >= len));
      chk(32'(n_dly[ch]), 32'(f >= dl));
    end
    // channel 1 counts the run-done pulse of channel 0's tick run
    wreg(OFF_CHANNEL_SELECT, 32'h1);
    wreg(OFF_RUN_LENGTH, 32'h1);
    wreg(OFF_COUNT_SOURCE, sv(SRC_CH0_RUN_DONE, QUAL_RISING));
    wreg(OFF_CHANNEL_SELECT, 32'h0);
    wreg(OFF_START_DELAY, 32'h0);
    wreg(OFF_RUN_LENGTH, 32'h3);
    wreg(OFF_COUNT_SOURCE, sv(SRC_MHZ_TICK, QUAL_ANY_EDGE));
    // three ticks need 750 cycles; the margin covers tick phase
    repeat (1000) @(posedge clk);
    rchk(OFF_LIVE_COUNT, 32'h3);
    rchk(OFF_CHANNEL_STATE, 32'h3);
    wreg(OFF_CHANNEL_SELECT, 32'h1);
    rchk(OFF_LIVE_COUNT, 32'h1);
    rchk(OFF_CHANNEL_STATE, 32'h3);
    wreg(OFF_RUN_LENGTH, 32'h0);
    wreg(OFF_START_DELAY, 32'h0);
    wreg(OFF_START_SOURCE, sv(5'(SRC_USER0 + 1), QUAL_RISING));
    wreg(OFF_COUNT_SOURCE, sv(SRC_USER0, QUAL_LEVEL_HIGH));
    rchk(OFF_CHANNEL_STATE, 32'h1);
    @(posedge clk);
    aux <= 1'b1;
    @(posedge clk);
    aux <= 1'b0;
    repeat (2) @(posedge clk);
    rchk(OFF_CHANNEL_STATE, 32'h2);
    k = $urandom_range(9, 1);
    pulse_pat(k);
    rchk(OFF_LIVE_COUNT, 32'(k));
    wreg(OFF_CLEAR_SOURCE, sv(5'(SRC_USER0 + 1), QUAL_FALLING));
    k = $urandom_range(9, 1);
    pulse_pat(k);
    @(posedge clk);
    aux <= 1'b1;
    repeat (3) @(posedge clk);
    aux <= 1'b0;
    repeat (2) @(posedge clk);
    rchk(OFF_CAPTURED, 32'(k));
    rchk(OFF_LIVE_COUNT, 32'h0);
    rchk(OFF_CHANNEL_STATE, 32'h2);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk(OFF_CHANNEL_SELECT, 32'h0);
    tally_and_finish();
  end
endmodule
